// file: logic/psg_pkg.sv
// Constants, types and helper functions for the programmable sound generator.
// Assumes one core clock and a host that writes command bytes over a parallel bus.
// Operation
// - Tone counters count down over 10 bits, reload the period and toggle the output.
// - Noise comes from a 15-bit shift register whose low bit is the output.
// - Noise shifts at one of three fixed rates or at tone two's rate.
// - Each of four channels has sixteen attenuation steps of 2 dB.
// - Attenuation code zero is loudest; larger codes are quieter.
// - The four attenuated channel levels are added digitally.
// - The sum leaves as an 8-bit sample word and as one PWM bit.
// - Each channel also has a PWM output pin of its own.
// - Channel levels swing between zero and the level, with no offset.
// - No select input; every strobed write is accepted.
// - A write completes in one clock; no not-ready indication exists.
// - All registers use one clock edge and a synchronous reset.
// - Byte 1cc0ffff stores the low four tone bits of channel cc.
// - Byte with bit 7 clear stores the upper six tone bits after a tone latch; after an attenuation or noise latch it writes that register.
// - Noise command holds a white/periodic bit and a two-bit rate code.
// - Byte 1cc1aaaa stores the attenuation of channel cc.
// - Rate codes 0, 1, 2 divide by 512, 1024, 2048; code 3 uses tone two.
// - Select codes 00 and 11 divide by 16, 01 by one, 10 by 128.
// - Square wave period is the period value times 32, 2 or 256 clocks.
// - Data on dedicated inputs, sample on outputs, strobe and selects on bidir pins.
// - Eight registers: four attenuations, three tone periods, one noise setting.
package psg_pkg;
   typedef logic [9:0] psg_period_type;
   typedef logic [3:0] psg_attn_type;
   typedef logic [5:0] psg_level_type;
   typedef logic [7:0] psg_byte_type;
   typedef logic [6:0] psg_div_type;
   typedef logic [14:0] psg_lfsr_type;

   localparam int NUM_TONE = 3;
   localparam int NUM_CHAN = 4;
   localparam logic [1:0] NOISE_CHAN = 2'h3;
   localparam int NOISE_TONE_SRC = 2;

   // Command byte fields.
   localparam int CMD_LATCH_BIT = 7;
   localparam int CMD_CHAN_HI = 6;
   localparam int CMD_CHAN_LO = 5;
   localparam int CMD_ATTN_BIT = 4;
   localparam int NOISE_WHITE_BIT = 2;

   // Bidirectional pin positions.
   localparam int PIN_WE_N = 0;
   localparam int PIN_SEL_LO = 1;
   localparam int PIN_SEL_HI = 2;
   localparam int PIN_CHAN0 = 3;
   localparam int PIN_MASTER = 7;
   localparam psg_byte_type BIDIR_OE = 8'hF8;

   // Prescaler select codes and last counter values.
   localparam logic [1:0] PRE_DIV16A = 2'h0;
   localparam logic [1:0] PRE_NONE = 2'h1;
   localparam logic [1:0] PRE_DIV128 = 2'h2;
   localparam logic [1:0] PRE_DIV16B = 2'h3;
   localparam psg_div_type PRE_LAST_16 = 7'h0F;
   localparam psg_div_type PRE_LAST_1 = 7'h00;
   localparam psg_div_type PRE_LAST_128 = 7'h7F;
   localparam psg_div_type DIV_ZERO = 7'h00;
   localparam psg_div_type DIV_ONE = 7'h01;

   // Noise half-rates in ticks; a shift every 32, 64 or 128 ticks of 16 clocks.
   localparam logic [1:0] NOISE_RATE_TONE2 = 2'h3;
   localparam psg_div_type NOISE_LAST_512 = 7'h0F;
   localparam psg_div_type NOISE_LAST_1024 = 7'h1F;
   localparam psg_div_type NOISE_LAST_2048 = 7'h3F;
   localparam psg_lfsr_type LFSR_SEED = 15'h4000;

   localparam psg_period_type TONE_ONE = 10'h001;
   localparam psg_period_type PERIOD_RESET = 10'h000;
   localparam psg_attn_type ATTN_LOUDEST = 4'h0;
   localparam psg_attn_type ATTN_SILENT = 4'hF;
   localparam logic [2:0] NOISE_CFG_RESET = 3'h0;
   localparam psg_level_type LEVEL_ZERO = 6'h00;
   localparam psg_level_type LEVEL_LOUDEST = 6'h3F;
   localparam psg_byte_type SAMPLE_ZERO = 8'h00;

   // Steps of 2 dB below full scale; the last code mutes the channel.
   localparam psg_level_type VOL_TABLE [16] = '{
      6'h3F, 6'h32, 6'h28, 6'h20, 6'h19, 6'h14, 6'h10, 6'h0D,
      6'h0A, 6'h08, 6'h06, 6'h05, 6'h04, 6'h03, 6'h03, 6'h00};

   function automatic psg_level_type vol_level(input psg_attn_type attn);
      return VOL_TABLE[attn];
   endfunction

   function automatic psg_div_type presc_last(input logic [1:0] sel);
      psg_div_type last;
      unique case (sel)
         PRE_NONE: last = PRE_LAST_1;
         PRE_DIV128: last = PRE_LAST_128;
         PRE_DIV16A, PRE_DIV16B: last = PRE_LAST_16;
      endcase
      return last;
   endfunction

   function automatic psg_div_type noise_last(input logic [1:0] rate);
      psg_div_type last;
      unique case (rate)
         2'h0: last = NOISE_LAST_512;
         2'h1: last = NOISE_LAST_1024;
         2'h2, NOISE_RATE_TONE2: last = NOISE_LAST_2048;
      endcase
      return last;
   endfunction
endpackage

// file: logic/psg_pwm.sv
// First-order pulse density modulator for one audio level.
// Assumes the level comes from the caller's registers, directly or through logic.
`timescale 1ns/1ns
module psg_pwm #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [W-1:0] duty,
   output logic pwm_out
);
   import psg_pkg::*;

   logic [W-1:0] acc_q;
   logic [W:0] acc_d;

   // The carry of an accumulator spreads the pulses, which eases the
   // external low-pass filter compared with a counter-compare modulator.
   always_comb
   begin
      acc_d = {1'b0, acc_q} + {1'b0, duty};
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         acc_q <= '0;
         pwm_out <= 1'b0;
      end
      else if (clk_en)
      begin
         acc_q <= acc_d[W-1:0];
         pwm_out <= acc_d[W];
      end
   end
endmodule

// file: logic/psg_top.sv
// Programmable sound generator: command decode, three tone channels,
// one noise channel, attenuation, digital mix and PWM outputs.
// Assumes all inputs are synchronous to core_clk and the host keeps
// the data stable while the write strobe is low.
`timescale 1ns/1ns
module psg_top (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire psg_pkg::psg_byte_type data_in,
   input wire psg_pkg::psg_byte_type bidir_in,
   output psg_pkg::psg_byte_type sample_out,
   output psg_pkg::psg_byte_type bidir_out,
   output psg_pkg::psg_byte_type bidir_oe
);
   import psg_pkg::*;

   logic write_strobe_n;
   logic prescale_select_low;
   logic prescale_select_high;
   logic [1:0] presc_sel;
   psg_div_type pre_cnt_q;
   logic tick;

   psg_period_type period_q [NUM_TONE];
   psg_period_type tone_cnt_q [NUM_TONE];
   logic [NUM_TONE-1:0] tone_bit_q;
   psg_attn_type attn_q [NUM_CHAN];
   logic [2:0] noise_cfg_q;
   logic noise_rate_code_low;
   logic noise_rate_code_high;
   logic [1:0] noise_rate;
   logic [1:0] latch_chan_q;
   logic latch_attn_q;
   logic we_n_q;

   logic wr;
   logic is_latch;
   logic [1:0] tgt_chan;
   logic tgt_attn;
   logic noise_restart;

   psg_div_type noise_cnt_q;
   logic noise_div_q;
   logic noise_src;
   logic noise_src_q;
   logic noise_shift;
   logic lfsr_fb;
   psg_lfsr_type lfsr_q;

   logic [NUM_CHAN-1:0] chan_on;
   psg_level_type chan_amp [NUM_CHAN];
   psg_byte_type mix;
   logic [NUM_CHAN-1:0] chan_pwm;
   logic master_pwm;

   assign write_strobe_n = bidir_in[PIN_WE_N];
   assign prescale_select_low = bidir_in[PIN_SEL_LO];
   assign prescale_select_high = bidir_in[PIN_SEL_HI];
   assign presc_sel = {prescale_select_high, prescale_select_low};

   // Prescaler: one tick every 16, 1 or 128 clocks. A compare with >= lets a
   // change of select mid-count recover within one wrap.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         pre_cnt_q <= DIV_ZERO;
      else if (clk_en)
         pre_cnt_q <= tick ? DIV_ZERO : pre_cnt_q + DIV_ONE;
   end

   assign tick = clk_en && (pre_cnt_q >= presc_last(presc_sel));

   // Command decode. There is no select input, so every low strobe writes.
   always_comb
   begin
      wr = clk_en && !write_strobe_n;
      is_latch = data_in[CMD_LATCH_BIT];
      tgt_chan = is_latch ? data_in[CMD_CHAN_HI:CMD_CHAN_LO] : latch_chan_q;
      tgt_attn = is_latch ? data_in[CMD_ATTN_BIT] : latch_attn_q;
      // Only the first cycle of a strobe restarts the noise register.
      noise_restart = wr && we_n_q && !tgt_attn && (tgt_chan == NOISE_CHAN);
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         we_n_q <= 1'b1;
      else if (clk_en)
         we_n_q <= write_strobe_n;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         latch_chan_q <= 2'h0;
         latch_attn_q <= 1'b0;
      end
      else if (wr && is_latch)
      begin
         latch_chan_q <= data_in[CMD_CHAN_HI:CMD_CHAN_LO];
         latch_attn_q <= data_in[CMD_ATTN_BIT];
      end
   end

   // Register file; each write lands in the cycle of the strobe.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < NUM_CHAN; i++)
            attn_q[i] <= ATTN_SILENT;
         for (int i = 0; i < NUM_TONE; i++)
            period_q[i] <= PERIOD_RESET;
         noise_cfg_q <= NOISE_CFG_RESET;
      end
      else if (wr)
      begin
         if (tgt_attn)
            attn_q[tgt_chan] <= data_in[3:0];
         else if (tgt_chan == NOISE_CHAN)
            noise_cfg_q <= data_in[2:0];
         else if (is_latch)
            period_q[tgt_chan][3:0] <= data_in[3:0];
         else
            period_q[tgt_chan][9:4] <= data_in[5:0];
      end
   end

   // Tone channels: a half period is the period value in ticks.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < NUM_TONE; i++)
            tone_cnt_q[i] <= PERIOD_RESET;
         tone_bit_q <= '0;
      end
      else if (tick)
      begin
         for (int i = 0; i < NUM_TONE; i++)
         begin
            if (tone_cnt_q[i] <= TONE_ONE)
            begin
               tone_cnt_q[i] <= period_q[i];
               tone_bit_q[i] <= ~tone_bit_q[i];
            end
            else
               tone_cnt_q[i] <= tone_cnt_q[i] - TONE_ONE;
         end
      end
   end

   assign noise_rate_code_low = noise_cfg_q[0];
   assign noise_rate_code_high = noise_cfg_q[1];
   assign noise_rate = {noise_rate_code_high, noise_rate_code_low};

   // Fixed noise rate: a square wave of 16, 32 or 64 ticks per half.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         noise_cnt_q <= DIV_ZERO;
         noise_div_q <= 1'b0;
      end
      else if (tick)
      begin
         if (noise_cnt_q >= noise_last(noise_rate))
         begin
            noise_cnt_q <= DIV_ZERO;
            noise_div_q <= ~noise_div_q;
         end
         else
            noise_cnt_q <= noise_cnt_q + DIV_ONE;
      end
   end

   always_comb
   begin
      noise_src = (noise_rate == NOISE_RATE_TONE2) ? tone_bit_q[NOISE_TONE_SRC]
         : noise_div_q;
      noise_shift = clk_en && noise_src && !noise_src_q;
      lfsr_fb = noise_cfg_q[NOISE_WHITE_BIT] ? (lfsr_q[0] ^ lfsr_q[1]) : lfsr_q[0];
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         noise_src_q <= 1'b0;
         lfsr_q <= LFSR_SEED;
      end
      else if (clk_en)
      begin
         noise_src_q <= noise_src;
         if (noise_restart)
            lfsr_q <= LFSR_SEED;
         else if (noise_shift)
            lfsr_q <= {lfsr_fb, lfsr_q[14:1]};
      end
   end

   // Attenuation and mix. A silent bit gives zero, never a negative swing.
   always_comb
   begin
      chan_on = {lfsr_q[0], tone_bit_q};
      mix = SAMPLE_ZERO;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         chan_amp[i] = chan_on[i] ? vol_level(attn_q[i]) : LEVEL_ZERO;
         mix = mix + {2'h0, chan_amp[i]};
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         sample_out <= SAMPLE_ZERO;
      else if (clk_en)
         sample_out <= mix;
   end

   psg_pwm #(.W(8)) u_master_pwm (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .duty(sample_out),
      .pwm_out(master_pwm)
   );

   for (genvar g = 0; g < NUM_CHAN; g++)
   begin : g_chan_pwm
      psg_pwm #(.W(6)) u_chan_pwm (
         .core_clk(core_clk),
         .nrst(nrst),
         .clk_en(clk_en),
         .duty(chan_amp[g]),
         .pwm_out(chan_pwm[g])
      );
   end

   // Pin outputs are re-registered so every port leaves a flip-flop.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         bidir_out <= SAMPLE_ZERO;
         bidir_oe <= BIDIR_OE;
      end
      else if (clk_en)
      begin
         bidir_out <= {master_pwm, chan_pwm, 3'h0};
         bidir_oe <= BIDIR_OE;
      end
   end

   a_tone_reload_toggle: assert property (@(posedge core_clk) disable iff (!nrst)
      (tick && tone_cnt_q[0] <= TONE_ONE) |=>
      (tone_cnt_q[0] == $past(period_q[0]) && tone_bit_q[0] != $past(tone_bit_q[0])))
      else $error("tone channel did not reload and toggle at zero");

   a_lfsr_shift_right: assert property (@(posedge core_clk) disable iff (!nrst)
      (noise_shift && !noise_restart) |=> (lfsr_q[13:0] == $past(lfsr_q[14:1])))
      else $error("noise register did not shift");

   a_noise_from_tone2: assert property (@(posedge core_clk) disable iff (!nrst)
      (noise_shift && noise_rate == NOISE_RATE_TONE2 && $stable(noise_cfg_q)) |->
      (tone_bit_q[NOISE_TONE_SRC] && $past(tone_bit_q[NOISE_TONE_SRC]) == 1'b0))
      else $error("noise shift not on tone two rising edge");

   a_attn_zero_loud: assert property (@(posedge core_clk) disable iff (!nrst)
      (lfsr_q[0] && attn_q[NOISE_CHAN] == ATTN_LOUDEST) |-> (chan_amp[3] == LEVEL_LOUDEST))
      else $error("attenuation zero is not the loudest level");

   a_level_no_offset: assert property (@(posedge core_clk) disable iff (!nrst)
      !tone_bit_q[1] |-> (chan_amp[1] == LEVEL_ZERO))
      else $error("silent half of a wave is not zero");

   a_fine_write_ch2: assert property (@(posedge core_clk) disable iff (!nrst)
      (wr && data_in[CMD_LATCH_BIT] && !data_in[CMD_ATTN_BIT]
       && data_in[CMD_CHAN_HI:CMD_CHAN_LO] == 2'h2) |=> (period_q[2][3:0] == $past(data_in[3:0])))
      else $error("fine tone write lost");

   a_coarse_write_ch2: assert property (@(posedge core_clk) disable iff (!nrst)
      (wr && !data_in[CMD_LATCH_BIT] && !latch_attn_q && latch_chan_q == 2'h2) |=>
      (period_q[2][9:4] == $past(data_in[5:0])))
      else $error("coarse tone write lost");

   a_attn_write_ch3: assert property (@(posedge core_clk) disable iff (!nrst)
      (wr && data_in[CMD_LATCH_BIT] && data_in[CMD_ATTN_BIT]
       && data_in[CMD_CHAN_HI:CMD_CHAN_LO] == NOISE_CHAN) |=> (attn_q[3] == $past(data_in[3:0])))
      else $error("attenuation write lost");

   // A switch to the undivided select ticks at once, which is legal.
   a_div16_spacing: assert property (@(posedge core_clk) disable iff (!nrst)
      (tick && presc_sel == PRE_DIV16A && pre_cnt_q == PRE_LAST_16) |=>
      (!tick || presc_sel == PRE_NONE) [*8])
      else $error("divide by 16 tick came too early");

   a_held_no_effect: assert property (@(posedge core_clk) disable iff (!nrst)
      (wr && !we_n_q && !noise_shift) |=> (lfsr_q == $past(lfsr_q)))
      else $error("held strobe disturbed the noise register");

   a_freeze_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      !clk_en |=> ($stable(sample_out) && $stable(bidir_out) && $stable(lfsr_q)))
      else $error("state moved while the clock enable was low");

   a_sync_reset_out: assert property (@(posedge core_clk)
      !nrst |=> (sample_out == SAMPLE_ZERO && bidir_oe == BIDIR_OE && lfsr_q == LFSR_SEED))
      else $error("synchronous reset not applied");
endmodule

// file: verif/psg_host_model.sv
// Host side of the sound generator: writes command bytes over the parallel bus.
// Assumes the bench calls write_byte and wires data_out and strobe_n to the block.
`timescale 1ns/1ns
module psg_host_model (
   input wire logic core_clk,
   output psg_pkg::psg_byte_type data_out,
   output logic strobe_n
);
   import psg_pkg::*;

   initial
   begin
      data_out = 8'h00;
      strobe_n = 1'b1;
   end

   // One clock after the strobe goes up the bus shows the inverse of the last byte, so a block
   // that samples outside the strobe picks up a wrong value instead of a lucky one.
   task automatic write_byte(input psg_byte_type b, input int hold);
      @(posedge core_clk);
      #5 data_out = b;
      @(posedge core_clk);
      #5 strobe_n = 1'b0;
      repeat (hold) @(posedge core_clk);
      #5 strobe_n = 1'b1;
      @(posedge core_clk);
      #5 data_out = ~b;
   endtask
endmodule

// file: verif/test_programmable_sound_generator.sv
// Self-checking bench for the sound generator: tone, noise, level and PWM checks.
// Assumes psg_top, psg_pkg and the host model are compiled before this file.
`timescale 1ns/1ns
`define CHECK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end

module test_programmable_sound_generator;
   import psg_pkg::*;
   typedef struct {psg_byte_type level; int span;} psg_note_type;

   localparam int LIMIT = 80000;
   localparam int MULT [4] = '{32, 2, 256, 32};
   localparam psg_byte_type LEVEL_TAB [16] = '{8'h3F, 8'h32, 8'h28, 8'h20, 8'h19, 8'h14,
      8'h10, 8'h0D, 8'h0A, 8'h08, 8'h06, 8'h05, 8'h04, 8'h03, 8'h03, 8'h00};

   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic [1:0] presc_sel = 2'h1;
   logic [4:0] spare_pins = 5'h00;
   logic strobe_n;
   psg_byte_type data_in;
   psg_byte_type sample_out;
   psg_byte_type bidir_out;
   psg_byte_type bidir_oe;
   psg_note_type note_q[$];
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int last_rise = 0;
   psg_byte_type prev_s = 8'h00;
   logic [4:0] pwm_seen = 5'h00;

   psg_host_model host_u (
      .core_clk(core_clk),
      .data_out(data_in),
      .strobe_n(strobe_n)
   );

   psg_top dut_u (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .data_in(data_in),
      .bidir_in({spare_pins, presc_sel, strobe_n}),
      .sample_out(sample_out),
      .bidir_out(bidir_out),
      .bidir_oe(bidir_oe)
   );

   always #25 core_clk = ~core_clk;

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Each rising step of the sample, from silence to a level, is one result.
   always @(posedge core_clk)
   begin
      psg_note_type n;
      cyc <= cyc + 1;
      pwm_seen <= pwm_seen | bidir_out[7:3];
      prev_s <= sample_out;
      if (prev_s === SAMPLE_ZERO && sample_out !== SAMPLE_ZERO)
      begin
         if (note_q.size() > 0)
         begin
            n = note_q.pop_front();
            `CHECK(sample_out, n.level)
            `CHECK(cyc - last_rise, n.span)
         end
         last_rise <= cyc;
      end
      if (cyc == LIMIT)
      begin
         err_count++;
         $display("wrong value at %0t: run did not finish", $time);
         end_of_test();
      end
   end

   task automatic silence_all();
      for (int c = 0; c < 4; c++)
      begin
         host_u.write_byte({1'b1, 2'(c), 1'b1, 4'hF}, 1);
      end
   endtask

   // The settle time covers a prescale change and leaves a rising step behind,
   // so the measured span never reaches back into the previous setting.
   task automatic expect_wave(input psg_byte_type lvl, input int span);
      psg_note_type n;
      repeat (3 * span + 20) @(posedge core_clk);
      #5;
      n.level = lvl;
      n.span = span;
      note_q.push_back(n);
      repeat (2 * span + 20) @(posedge core_clk);
      #5;
      `CHECK(note_q.size(), 0)
   endtask

   initial
   begin
      logic [1:0] ch;
      psg_attn_type lo;
      psg_attn_type at;
      psg_byte_type held_s;
      psg_byte_type held_b;
      void'($urandom(32'hA833));
      repeat (20) @(posedge core_clk);
      #5 nrst = 1'b1;
      spare_pins = 5'($urandom());
      @(posedge core_clk);
      #5;
      `CHECK(sample_out, SAMPLE_ZERO)
      `CHECK(bidir_oe, BIDIR_OE)
      `CHECK(bidir_out, 8'h00)
      $display("reset test done");

      for (int s = 0; s < 4; s++)
      begin
         ch = 2'($urandom_range(2));
         lo = 4'($urandom());
         at = 4'($urandom_range(14));
         presc_sel = 2'(s);
         spare_pins = 5'($urandom());
         silence_all();
         host_u.write_byte({1'b1, ch, 1'b0, lo}, 1);
         host_u.write_byte(8'h01, 1 + s);
         host_u.write_byte({1'b1, ch, 1'b1, at}, 1);
         pwm_seen = 5'h00;
         expect_wave(LEVEL_TAB[at], (16 + lo) * MULT[s]);
         `CHECK(pwm_seen, 5'h10 | (5'h01 << ch))
         $display("tone test done, select %0d channel %0d", s, ch);
      end

      presc_sel = PRE_NONE;
      for (int r = 0; r < 4; r++)
      begin
         lo = 4'($urandom());
         silence_all();
         host_u.write_byte({1'b1, 2'h2, 1'b0, lo}, 1);
         host_u.write_byte(8'h01, 1);
         host_u.write_byte(8'hE0 | 8'(r), 2);
         host_u.write_byte(8'hF0, 1);
         pwm_seen = 5'h00;
         expect_wave(LEVEL_TAB[0], r == 3 ? 30 * (16 + lo) : 480 << r);
         `CHECK(pwm_seen, 5'h18)
         $display("noise test done, rate %0d", r);
      end

      // A frozen block must hold the sample and the pin outputs, even with a loud tone running.
      host_u.write_byte(8'h90, 1);
      clk_en = 1'b0;
      @(posedge core_clk);
      #5;
      held_s = sample_out;
      held_b = bidir_out;
      repeat (40) @(posedge core_clk);
      #5;
      `CHECK(sample_out, held_s)
      `CHECK(bidir_out, held_b)
      clk_en = 1'b1;
      $display("freeze test done");
      end_of_test();
   end
endmodule
